// ---- bfou_pkg.sv ----
// bfou_pkg: shared constants and types of the bit field ops unit
// assumes 64-bit operand registers, bit 0 leftmost, held as [63:0] with [63:48] the length
`default_nettype none

package bfou_pkg;

   // ---------------------------------------------------------------
   // operand layout
   // ---------------------------------------------------------------
   localparam int REG_W = 64;
   localparam int LEN_W = 16;
   localparam int ADDR_W = 48;
   localparam int LEN_HI = 63;
   localparam int LEN_LO = 48;
   // data flag bit that the lead-bit flag stands for in the wider machine
   localparam int DFLAG_LEAD_BIT = 53;

   // ---------------------------------------------------------------
   // buffering
   // ---------------------------------------------------------------
   localparam int BFOU_FIFO_DEPTH = 16;
   localparam int BFOU_FIFO_WIDTH = 1;

   // ---------------------------------------------------------------
   // constants for counters and fills
   // ---------------------------------------------------------------
   localparam logic [LEN_W-1:0] LEN_ZERO = 16'h0;
   localparam logic [LEN_W-1:0] LEN_ONE = 16'h1;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 48'h0;
   localparam logic [REG_W-1:0] REG_ZERO = 64'h0;

   // ---------------------------------------------------------------
   // operations and states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_COMPRESS = 3'h0,
      OP_MERGE = 3'h1,
      OP_MASK = 3'h2,
      OP_LZMASK = 3'h3,
      OP_LOMASK = 3'h4,
      OP_CLE = 3'h5
   } bfou_op_e;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_FILL = 4'h2,
      ST_SCAN = 4'h4,
      ST_FINISH = 4'h8
   } bfou_state_e;

endpackage

`default_nettype wire

// ---- bfou_fifo.sv ----
// bfou_fifo: valid/ready FIFO between bit producer and destination writer
// assumes one clock, synchronous active-high reset
`default_nettype none

module bfou_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW-1:0] wrPtr_r;
   logic [PW-1:0] rdPtr_r;
   logic [PW:0] count_r;
   wire logic push;
   wire logic pop;
   wire logic [PW-1:0] lastIdx;

   assign lastIdx = PW'(DEPTH - 1);
   assign inReady = count_r != (PW+1)'(DEPTH);
   assign outValid = count_r != '0;
   assign outData = mem_r[rdPtr_r];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_r[wrPtr_r] <= inData;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wrPtr_r <= (wrPtr_r == lastIdx) ? '0 : wrPtr_r + 1'b1;
         end
         if (pop) begin
            rdPtr_r <= (rdPtr_r == lastIdx) ? '0 : rdPtr_r + 1'b1;
         end
         count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

endmodule

`default_nettype wire

// ---- bfou_seg_ptr.sv ----
// bfou_seg_ptr: bit address pointer of one source field
// assumes the caller steps once per consumed bit and flags the segment's last bit
`default_nettype none

module bfou_seg_ptr #(
   parameter int AW = 48,
   parameter int LW = 16
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // control
   input wire logic load,
   input wire logic [AW-1:0] loadAddr,
   input wire logic step,
   input wire logic skip,
   input wire logic [LW-1:0] skipLen,
   // pointer
   output logic [AW-1:0] addr
);
   logic [AW-1:0] addr_r;
   wire logic [AW-1:0] skipExt;
   wire logic [AW-1:0] stepAmt;

   // skipping at the end of a segment jumps over bits the field never sends
   assign skipExt = {{(AW-LW){1'b0}}, skipLen};
   assign stepAmt = skip ? skipExt + AW'(1) : AW'(1);
   assign addr = addr_r;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         addr_r <= '0;
      end else if (load) begin
         addr_r <= loadAddr;
      end else if (step) begin
         addr_r <= addr_r + stepAmt;
      end
   end

endmodule

`default_nettype wire

// ---- bfou_unit.sv ----
// bfou_unit: bit-string execution unit (compress, merge, mask, repeated masks, leading equals)
// assumes a bit-granular memory: one read outstanding, answered once by memRdValid
//
// Notes on behaviour
// RL1: compress length, base from R; skip from S
// RL2: compress copies run, skips run, until destination full
// RL3: compress zero source or destination length: no-op
// RL4: merge/mask take length and base per register
// RL5: merge alternates R segment then S segment
// RL6: S base zero fills S segments with zeros
// RL7: merge/mask any zero length: no-op
// RL8: mask fields advance by both lengths each period
// RL9: leading-zeros mask: zeros then ones per period
// RL10: zero period no-op; edge runs give all zeros/ones
// RL11: leading-ones mask: ones then zeros per period
// RL12: zero period no-op; edge runs give all ones/zeros
// RL13: software keeps run not above period length
// RL14: masks write destination from T until exhausted
// RL15: count bits equal to first, result in T
// RL16: scan start is R base plus S index
// RL17: whole result register cleared before count stored
// RL18: full match stores field length minus one
// RL19: lead flag cleared at start, set if first one
// RL20: partial final segment; nothing past destination written
`default_nettype none

module bfou_unit
   import bfou_pkg::*;
#(
   parameter int FIFO_DEPTH = BFOU_FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // instruction issue
   input wire logic cmdValid,
   output logic cmdReady,
   input wire bfou_op_e cmdOp,
   input wire logic [REG_W-1:0] regR,
   input wire logic [REG_W-1:0] regS,
   input wire logic [REG_W-1:0] regT,
   // completion
   output logic doneP,
   output logic [REG_W-1:0] resT,
   output logic flagLeadOne,
   // memory read
   output logic memRdReq,
   output logic [ADDR_W-1:0] memRdAddr,
   input wire logic memRdValid,
   input wire logic memRdBit,
   // memory write
   output logic memWrValid,
   input wire logic memWrReady,
   output logic [ADDR_W-1:0] memWrAddr,
   output logic memWrBit
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   bfou_state_e state_r;
   bfou_op_e op_r;
   logic [LEN_W-1:0] lenA_r, lenB_r, skipA_r, skipB_r;
   logic [LEN_W-1:0] segLeft_r, prodLeft_r, wrLeft_r, cleCnt_r;
   logic memA_r, memB_r, constA_r, constB_r, phaseB_r;
   logic rdPend_r, memRdReq_r, cleFirst_r, cleHave_r, done_r, flag_r;
   logic [ADDR_W-1:0] rdAddr_r, wrAddr_r;
   logic [REG_W-1:0] resT_r;

   // ---------------------------------------------------------------
   // operand decode
   // ---------------------------------------------------------------
   wire logic [LEN_W-1:0] lenR = regR[LEN_HI:LEN_LO]; // RL1 RL4
   wire logic [LEN_W-1:0] lenS = regS[LEN_HI:LEN_LO];
   wire logic [LEN_W-1:0] lenT = regT[LEN_HI:LEN_LO]; // RL14
   wire logic [ADDR_W-1:0] baseR = regR[ADDR_W-1:0];
   wire logic [ADDR_W-1:0] baseS = regS[ADDR_W-1:0];
   wire logic [ADDR_W-1:0] baseT = regT[ADDR_W-1:0];
   wire logic sBaseZero = baseS == ADDR_ZERO; // RL6
   wire logic isCmp = cmdOp == OP_COMPRESS;
   wire logic isPair = (cmdOp == OP_MERGE) || (cmdOp == OP_MASK);
   wire logic isRep = (cmdOp == OP_LZMASK) || (cmdOp == OP_LOMASK);
   wire logic isCle = cmdOp == OP_CLE;
   wire logic nopCmp = isCmp && (lenR == LEN_ZERO || lenT == LEN_ZERO); // RL3
   wire logic nopPair = isPair && (lenR == LEN_ZERO || lenS == LEN_ZERO || lenT == LEN_ZERO); // RL7
   wire logic nopRep = isRep && (lenS == LEN_ZERO || lenT == LEN_ZERO); // RL10 RL12
   wire logic isNop = nopCmp || nopPair || nopRep || (isCle && lenR == LEN_ZERO);
   wire logic accept = cmdValid && cmdReady;

   // segment plan: A is the R segment or leading run, B the S segment or trailing run
   wire logic [LEN_W-1:0] planLenA = lenR; // RL5
   wire logic [LEN_W-1:0] planLenB = isCmp ? LEN_ZERO : (isRep ? lenS - lenR : lenS); // RL9 RL11
   wire logic [LEN_W-1:0] planSkipA = (isCmp || cmdOp == OP_MASK) ? lenS : LEN_ZERO; // RL2 RL8
   wire logic [LEN_W-1:0] planSkipB = (cmdOp == OP_MASK) ? lenR : LEN_ZERO; // RL8
   wire logic [ADDR_W-1:0] lenRExt = {{(ADDR_W-LEN_W){1'b0}}, lenR};
   wire logic [ADDR_W-1:0] loadA = isCle ? baseR + regS[ADDR_W-1:0] : baseR; // RL16
   wire logic [ADDR_W-1:0] loadB = (cmdOp == OP_MASK) ? baseS + lenRExt : baseS; // RL8

   // ---------------------------------------------------------------
   // producer: fills the FIFO from memory or from constants
   // ---------------------------------------------------------------
   wire logic [ADDR_W-1:0] ptrA, ptrB;
   wire logic fifoInReady, fifoOutValid, fifoOutBit;
   wire logic inFill = state_r == ST_FILL;
   wire logic inScan = state_r == ST_SCAN;
   wire logic curMem = phaseB_r ? memB_r : memA_r;
   wire logic curConst = phaseB_r ? constB_r : constA_r;
   wire logic prodBusy = inFill && prodLeft_r != LEN_ZERO;
   // one read at a time and only with room: the answer always fits in the FIFO
   wire logic issueFill = prodBusy && curMem && !rdPend_r && fifoInReady;
   wire logic issueScan = inScan && !rdPend_r;
   wire logic rdResp = rdPend_r && memRdValid;
   wire logic pushConst = prodBusy && !curMem && fifoInReady;
   wire logic fifoInValid = pushConst || (inFill && rdResp);
   wire logic fifoInBit = pushConst ? curConst : memRdBit;
   wire logic advance = fifoInValid && fifoInReady;
   wire logic segEnd = advance && segLeft_r == LEN_ONE;
   wire logic nextPhaseB = phaseB_r ? (lenA_r == LEN_ZERO) : (lenB_r != LEN_ZERO); // RL5
   wire logic fillLast = advance && prodLeft_r == LEN_ONE; // RL20
   wire logic scanResp = inScan && rdResp;
   wire logic scanEqual = memRdBit == cleFirst_r;
   wire logic scanLast = scanResp && (prodLeft_r == LEN_ONE || (cleHave_r && !scanEqual)); // RL15 RL18
   wire logic [LEN_W-1:0] cleCntNxt = (scanResp && cleHave_r && scanEqual) ? cleCnt_r + LEN_ONE : cleCnt_r;
   wire logic wrFire = memWrValid && memWrReady;
   wire logic finishing = (state_r == ST_FINISH) && wrLeft_r == LEN_ZERO;

   bfou_seg_ptr #(.AW(ADDR_W), .LW(LEN_W)) u_ptrA (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .load(accept),
      .loadAddr(loadA),
      .step((advance && !phaseB_r) || scanResp),
      .skip(segEnd && !phaseB_r),
      .skipLen(skipA_r),
      .addr(ptrA)
   );

   bfou_seg_ptr #(.AW(ADDR_W), .LW(LEN_W)) u_ptrB (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .load(accept),
      .loadAddr(loadB),
      .step(advance && phaseB_r),
      .skip(segEnd && phaseB_r),
      .skipLen(skipB_r),
      .addr(ptrB)
   );

   // the FIFO decouples memory reads from destination writes
   bfou_fifo #(.WIDTH(BFOU_FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .inValid(fifoInValid),
      .inReady(fifoInReady),
      .inData(fifoInBit),
      .outValid(fifoOutValid),
      .outReady(memWrReady),
      .outData(fifoOutBit)
   );

   assign cmdReady = state_r == ST_IDLE;
   assign doneP = done_r;
   assign resT = resT_r;
   assign flagLeadOne = flag_r;
   assign memRdReq = memRdReq_r;
   assign memRdAddr = rdAddr_r;
   assign memWrValid = fifoOutValid;
   assign memWrAddr = wrAddr_r;
   assign memWrBit = fifoOutBit;

   // ---------------------------------------------------------------
   // control state machine
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_r <= ST_IDLE;
         done_r <= 1'b0;
      end else begin
         done_r <= finishing;
         case (state_r)
            ST_IDLE: begin
               if (accept) begin
                  state_r <= isNop ? ST_FINISH : (isCle ? ST_SCAN : ST_FILL); // RL3 RL7 RL10 RL12
               end
            end
            ST_FILL: begin
               if (fillLast) begin
                  state_r <= ST_FINISH;
               end
            end
            ST_SCAN: begin
               if (scanLast) begin
                  state_r <= ST_FINISH;
               end
            end
            ST_FINISH: begin
               if (finishing) begin
                  state_r <= ST_IDLE;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // segment plan registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         op_r <= OP_COMPRESS;
         lenA_r <= LEN_ZERO;
         lenB_r <= LEN_ZERO;
         skipA_r <= LEN_ZERO;
         skipB_r <= LEN_ZERO;
         memA_r <= 1'b0;
         memB_r <= 1'b0;
         constA_r <= 1'b0;
         constB_r <= 1'b0;
      end else if (accept) begin
         op_r <= cmdOp;
         lenA_r <= planLenA;
         lenB_r <= planLenB;
         skipA_r <= planSkipA;
         skipB_r <= planSkipB;
         memA_r <= !isRep;
         memB_r <= isPair && !sBaseZero; // RL6
         constA_r <= cmdOp == OP_LOMASK; // RL9 RL11
         constB_r <= cmdOp == OP_LZMASK;
      end
   end

   // ---------------------------------------------------------------
   // counters and phase
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         phaseB_r <= 1'b0;
         segLeft_r <= LEN_ZERO;
         prodLeft_r <= LEN_ZERO;
      end else if (accept) begin
         phaseB_r <= planLenA == LEN_ZERO; // RL10 RL12
         segLeft_r <= (planLenA == LEN_ZERO) ? planLenB : planLenA;
         prodLeft_r <= isNop ? LEN_ZERO : (isCle ? lenR : lenT); // RL2 RL14
      end else if (advance || scanResp) begin
         prodLeft_r <= prodLeft_r - LEN_ONE;
         if (segEnd) begin
            phaseB_r <= nextPhaseB;
            segLeft_r <= nextPhaseB ? lenB_r : lenA_r;
         end else if (advance) begin
            segLeft_r <= segLeft_r - LEN_ONE;
         end
      end
   end

   // ---------------------------------------------------------------
   // memory read port
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rdPend_r <= 1'b0;
         memRdReq_r <= 1'b0;
         rdAddr_r <= ADDR_ZERO;
      end else begin
         memRdReq_r <= issueFill || issueScan;
         if (issueFill || issueScan) begin
            rdPend_r <= 1'b1;
            rdAddr_r <= phaseB_r ? ptrB : ptrA;
         end else if (rdResp) begin
            rdPend_r <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // destination writer
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wrLeft_r <= LEN_ZERO;
         wrAddr_r <= ADDR_ZERO;
      end else if (accept) begin
         wrLeft_r <= (isNop || isCle) ? LEN_ZERO : lenT; // RL14 RL20
         wrAddr_r <= baseT;
      end else if (wrFire) begin
         wrLeft_r <= wrLeft_r - LEN_ONE;
         wrAddr_r <= wrAddr_r + ADDR_W'(1);
      end
   end

   // ---------------------------------------------------------------
   // leading equals scan and result
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cleFirst_r <= 1'b0;
         cleHave_r <= 1'b0;
         cleCnt_r <= LEN_ZERO;
         flag_r <= 1'b0;
         resT_r <= REG_ZERO;
      end else if (accept && isCle) begin
         cleHave_r <= 1'b0;
         cleCnt_r <= LEN_ZERO;
         flag_r <= 1'b0; // RL19
         resT_r <= REG_ZERO; // RL17
      end else if (scanResp) begin
         cleCnt_r <= cleCntNxt;
         if (!cleHave_r) begin
            cleHave_r <= 1'b1;
            cleFirst_r <= memRdBit;
            flag_r <= memRdBit; // RL19
         end
         if (scanLast) begin
            resT_r <= {{(REG_W-LEN_W){1'b0}}, cleCntNxt}; // RL15 RL18
         end
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_nop_accept;
      cmdValid && cmdReady && isNop && !isCle;
   endsequence

   sequence s_quiet_then_done;
      (!memWrValid && !memRdReq) ##1 (doneP && !memWrValid);
   endsequence

   a_nop_no_write: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL3
      s_nop_accept |=> s_quiet_then_done) else $error("no-op wrote memory or missed done");

   a_compress_src_base: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL1
      (accept && isCmp && !isNop) |=> (ptrA == $past(baseR) && skipA_r == $past(lenS)))
      else $error("compress source base or skip length wrong");

   a_write_in_field: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL20
      wrFire |-> wrLeft_r != LEN_ZERO) else $error("write past destination field");

   a_dest_start: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL14
      (accept && !isNop && !isCle) |=> (memWrAddr == $past(baseT) && wrLeft_r == $past(lenT)))
      else $error("destination start or length wrong");

   a_zero_fill_seg: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL6
      (fifoInValid && phaseB_r && (op_r == OP_MERGE || op_r == OP_MASK) && !memB_r) |-> !fifoInBit)
      else $error("zero base S segment not zero filled");

   a_lz_pattern: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL9
      (fifoInValid && op_r == OP_LZMASK) |-> fifoInBit == phaseB_r) else $error("leading zeros pattern wrong");

   a_lo_pattern: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL11
      (fifoInValid && op_r == OP_LOMASK) |-> fifoInBit != phaseB_r) else $error("leading ones pattern wrong");

   a_mask_s_base: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL8
      (accept && cmdOp == OP_MASK && !isNop) |=> ptrB == $past(baseS) + $past(lenRExt))
      else $error("mask second field start wrong");

   a_cle_flag_clear: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL19
      (accept && isCle) |=> (!flagLeadOne && resT == REG_ZERO)) else $error("scan start did not clear flag or result");

   a_cle_result_low: assert property (@(posedge clk_sys) disable iff (sys_rst) // RL17
      (scanLast) |=> (resT[REG_W-1:LEN_W] == '0 && resT[LEN_W-1:0] < $past(lenA_r) + LEN_ONE) ##1 doneP)
      else $error("count result malformed or done late");

endmodule

`default_nettype wire

// ---- bfou_mem.sv ----
// bfou_mem: bit-granular central memory model on the far side of bfou_unit
// assumes one read outstanding; slow adds read latency and long write stalls
`default_nettype none

module bfou_mem (
   // clock and pacing
   input wire logic clk_sys,
   input wire logic slow,
   // read port
   input wire logic memRdReq,
   input wire logic [47:0] memRdAddr,
   output logic memRdValid,
   output logic memRdBit,
   // write port
   input wire logic memWrValid,
   output logic memWrReady,
   input wire logic [47:0] memWrAddr,
   input wire logic memWrBit
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // storage: 256 bits, the bench keeps every field inside
   // ---------------------------------------------------------------
   logic [255:0] mem;
   logic pend;
   logic [7:0] rdAddr;
   logic dly;
   logic [5:0] tick;

   initial begin
      memRdValid = 1'b0;
      memRdBit = 1'b0;
      memWrReady = 1'b0;
      pend = 1'b0;
      dly = 1'b0;
      tick = 6'h0;
   end

   always @(posedge clk_sys) begin
      memRdValid <= pend && !dly && !memRdReq;
      // junk between answers, so a stale bit never passes for data
      memRdBit <= (pend && !dly && !memRdReq) ? mem[rdAddr] : ~memRdBit;
      tick <= tick + 6'h1;
      // when slow, half of every 64 cycles refused; reads at four or more cycles per bit cannot fill the fifo
      memWrReady <= ~slow | tick[5];
      if (memRdReq) begin
         pend <= 1'b1;
         rdAddr <= memRdAddr[7:0];
         dly <= slow & tick[0];
      end else if (pend && dly) begin
         dly <= 1'b0;
      end else if (pend) begin
         pend <= 1'b0;
      end
      if (memWrValid && memWrReady) begin
         mem[memWrAddr[7:0]] <= memWrBit;
      end
   end
endmodule

`default_nettype wire

// ---- tb_bit_field_ops_unit.sv ----
// tb_bit_field_ops_unit: self-checking bench of bfou_unit against a bit memory
// assumes bfou_pkg, bfou_unit, bfou_fifo, bfou_seg_ptr and bfou_mem compiled first
`default_nettype none

module tb_bit_field_ops_unit import bfou_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // signals and instances
   // ---------------------------------------------------------------
   localparam logic [255:0] INIT = {4{64'h5a3c_ffff_9e61_c7b2}};
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic cmdValid = 1'b0;
   bfou_op_e cmdOp = OP_COMPRESS;
   logic [63:0] regR = 64'h0;
   logic [63:0] regS = 64'h0;
   logic [63:0] regT = 64'h0;
   logic slow = 1'b0;
   logic cmdReady, doneP, flagLeadOne, memRdReq, memRdValid, memRdBit, memWrValid, memWrReady, memWrBit;
   logic [63:0] resT;
   logic [47:0] memRdAddr, memWrAddr;
   int failures = 0;
   int n_tests = 0;

   bfou_unit #(.FIFO_DEPTH(16)) i_bfou_unit (.clk_sys(clk_sys), .sys_rst(sys_rst), .cmdValid(cmdValid),
      .cmdReady(cmdReady), .cmdOp(cmdOp), .regR(regR), .regS(regS), .regT(regT), .doneP(doneP), .resT(resT),
      .flagLeadOne(flagLeadOne), .memRdReq(memRdReq), .memRdAddr(memRdAddr), .memRdValid(memRdValid),
      .memRdBit(memRdBit), .memWrValid(memWrValid), .memWrReady(memWrReady), .memWrAddr(memWrAddr),
      .memWrBit(memWrBit));
   bfou_mem i_bfou_mem (.clk_sys(clk_sys), .slow(slow), .memRdReq(memRdReq), .memRdAddr(memRdAddr),
      .memRdValid(memRdValid), .memRdBit(memRdBit), .memWrValid(memWrValid), .memWrReady(memWrReady),
      .memWrAddr(memWrAddr), .memWrBit(memWrBit));

   initial begin
      forever #2.5 clk_sys = ~clk_sys;
   end

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input logic ok, input string what);
      n_tests++;
      if (ok !== 1'b1) begin
         failures++;
         $display("MISMATCH at %0t: %s", $time, what);
      end
   endtask

   // offers one command, returns negedges from accept to doneP (2 for a no-op)
   task automatic issue(input bfou_op_e op, input logic [63:0] r, s, t, output int n);
      check(cmdReady === 1'b1, "unit not idle before issue");
      @(posedge clk_sys);
      cmdValid <= 1'b1;
      cmdOp <= op;
      regR <= r;
      regS <= s;
      regT <= t;
      @(posedge clk_sys);
      cmdValid <= 1'b0;
      n = 0;
      while (doneP !== 1'b1 && n < 4000) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 4000) begin
         failures++;
         $display("MISMATCH at %0t: no completion", $time);
         conclude();
      end
   endtask

   // runs a field op and compares all memory with the image built here
   task automatic run(input bfou_op_e op, input logic [63:0] r, s, t, input int expN);
      logic [255:0] ex;
      int lr, ls, lt, p, i, j, q, n;
      logic nop;
      lr = int'(r[63:48]);
      ls = int'(s[63:48]);
      lt = int'(t[63:48]);
      p = lr + ls;
      nop = lt == 0 || (op <= OP_MASK && lr == 0) || (op != OP_COMPRESS && ls == 0);
      i_bfou_mem.mem = INIT;
      ex = INIT;
      for (i = 0; i < lt && !nop; i++) begin
         j = i % p;
         q = i / p;
         case (op)
            OP_COMPRESS: ex[t[7:0] + i] = INIT[r[7:0] + (i / lr) * p + i % lr];
            OP_MERGE: ex[t[7:0] + i] = j < lr ? INIT[r[7:0] + q * lr + j] :
               (s[47:0] == 48'h0 ? 1'b0 : INIT[s[7:0] + q * ls + j - lr]);
            OP_MASK: ex[t[7:0] + i] = j < lr ? INIT[r[7:0] + q * p + j] :
               (s[47:0] == 48'h0 ? 1'b0 : INIT[s[7:0] + q * p + j]);
            OP_LZMASK: ex[t[7:0] + i] = (i % ls) >= lr;
            default: ex[t[7:0] + i] = (i % ls) < lr;
         endcase
      end
      issue(op, r, s, t, n);
      check(i_bfou_mem.mem === ex, $sformatf("memory image, op %0d", op));
      if (expN > 0) begin
         check(n == expN, $sformatf("no-op completion took %0d", n));
      end
   endtask

   task automatic cle(input logic [63:0] r, s);
      int a, k, n;
      logic b0;
      a = int'(r[7:0]) + int'(s[7:0]);
      b0 = INIT[a];
      for (k = 1; k < int'(r[63:48]) && INIT[a + k] == b0; k++);
      i_bfou_mem.mem = INIT;
      issue(OP_CLE, r, s, {16'h0, 48'h90}, n);
      check(resT === {48'h0, 16'(k - 1)}, "leading equal count");
      check(flagLeadOne === b0, "lead bit flag");
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic s_compress;
      slow = 1'b1;
      run(OP_COMPRESS, {16'h3, 48'h0}, {16'h2, 48'h0}, {16'h28, 48'h80}, 0);
      slow = 1'b0;
      run(OP_COMPRESS, {16'h1, 48'h5}, {16'h0, 48'h0}, {16'h7, 48'h80}, 0);
   endtask

   task automatic s_merge_mask;
      run(OP_MERGE, {16'h2, 48'h3}, {16'h3, 48'h40}, {16'h0c, 48'h80}, 0);
      run(OP_MERGE, {16'h2, 48'h3}, {16'h3, 48'h0}, {16'h0d, 48'h80}, 0);
      slow = 1'b1;
      run(OP_MASK, {16'h3, 48'h1}, {16'h2, 48'h40}, {16'h2d, 48'h80}, 0);
      slow = 1'b0;
      run(OP_MASK, {16'h3, 48'h1}, {16'h2, 48'h0}, {16'h0d, 48'h80}, 0);
   endtask

   // runs never above the period, undefined otherwise
   task automatic s_masks;
      bfou_op_e op;
      for (int k = 0; k < 2; k++) begin
         op = k == 0 ? OP_LZMASK : OP_LOMASK;
         run(op, {16'h2, 48'h7}, {16'h5, 48'h9}, {16'h0c, 48'h81}, 0);
         run(op, {16'h0, 48'h0}, {16'h4, 48'h0}, {16'h09, 48'h80}, 0);
         run(op, {16'h4, 48'h0}, {16'h4, 48'h0}, {16'h09, 48'h80}, 0);
      end
   endtask

   task automatic s_noops;
      bfou_op_e op;
      for (int k = 0; k < 5; k++) begin
         op = bfou_op_e'(k);
         run(op, {16'h0, 48'h1}, {16'h2, 48'h40}, {16'h8, 48'h80}, k >= 3 ? 0 : 2);
         run(op, {16'h2, 48'h1}, {16'h0, 48'h40}, {16'h8, 48'h80}, k == 0 ? 0 : 2);
         run(op, {16'h2, 48'h1}, {16'h2, 48'h40}, {16'h0, 48'h80}, 2);
      end
   endtask

   task automatic s_cle;
      cle({16'h10, 48'h1e}, {16'h0, 48'h2});
      cle({16'h14, 48'h0}, {16'h0, 48'h2});
      cle({16'h0c, 48'h40}, {16'h0, 48'h9});
   endtask

   initial begin
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (2) @(negedge clk_sys);
      s_compress();
      s_merge_mask();
      s_masks();
      s_noops();
      s_cle();
      conclude();
   end
endmodule

`default_nettype wire
